// [rtl/csx_pkg.sv]
// Purpose: shared constants for the compare/skip/adjust/decrement slice
// Assumes: one core clock, four phases per instruction cycle
// Notes: opcodes are matched on the upper byte of the instruction word, decimal adjust on the whole word
package csx_pkg;
    // ------------------------------------------------------------------
    // opcode patterns (upper byte, masked; decimal adjust is the whole word)
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_CMP_MASK = 8'hfe;
    localparam logic [7:0] OP_CMP_LESS = 8'h60;
    localparam logic [7:0] OP_CMP_EQUAL = 8'h62;
    localparam logic [7:0] OP_CMP_GREATER = 8'h64;
    localparam logic [7:0] OP_DEC_MASK = 8'hfc;
    localparam logic [7:0] OP_DEC_FILE = 8'h04;
    localparam logic [15:0] OP_DECIMAL_ADJUST = 16'h0007;
    // ------------------------------------------------------------------
    // field positions in the instruction word
    // ------------------------------------------------------------------
    localparam int BIT_BANK_MODE = 8;
    localparam int BIT_DEST = 9;
    // ------------------------------------------------------------------
    // addressing and arithmetic constants
    // ------------------------------------------------------------------
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [3:0] BCD_CORRECTION = 4'h6;
    localparam logic [3:0] ACCESS_BANK = 4'hf;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    // status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    // ------------------------------------------------------------------
    // phase sequencer (gray order q1-q2-q3-q4)
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } csx_phase_t;
    typedef enum logic [1:0] {
        EX_RUN = 2'b00,
        EX_SKIP1 = 2'b01,
        EX_SKIP2 = 2'b11
    } csx_exec_t;
endpackage : csx_pkg

// [rtl/csx_phase.sv]
// Purpose: four-phase generator for the instruction cycle
// Assumes: synchronous active-high reset
// Notes: q1 follows reset release
module csx_phase (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // phase
    output csx_pkg::csx_phase_t phase
);
    csx_pkg::csx_phase_t ph_r;
    csx_pkg::csx_phase_t ph_nxt;

    always_comb
    begin
        case (ph_r)
            csx_pkg::PH_Q1: ph_nxt = csx_pkg::PH_Q2;
            csx_pkg::PH_Q2: ph_nxt = csx_pkg::PH_Q3;
            csx_pkg::PH_Q3: ph_nxt = csx_pkg::PH_Q4;
            default: ph_nxt = csx_pkg::PH_Q1;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            ph_r <= csx_pkg::PH_Q1;
        else
            ph_r <= ph_nxt;
    end

    assign phase = ph_r;
endmodule : csx_phase

// [rtl/csx_bcd_adjust.sv]
// Purpose: packed-bcd correction of the accumulator
// Assumes: purely combinational
// Notes: carry out is the fifth bit of the high-nibble sum
module csx_bcd_adjust (
    // operand and flags in
    input wire logic [7:0] acc,
    input wire logic half_carry,
    input wire logic carry,
    // result
    output logic [7:0] result,
    output logic carry_out
);
    logic [4:0] lo_sum;
    logic [4:0] hi_base;
    logic [4:0] hi_sum;

    always_comb
    begin
        lo_sum = {1'b0, acc[3:0]};
        if ((acc[3:0] > csx_pkg::BCD_DIGIT_MAX) || half_carry)
            lo_sum = {1'b0, acc[3:0]} + {1'b0, csx_pkg::BCD_CORRECTION};
        hi_base = {1'b0, acc[7:4]} + {4'h0, half_carry};
        hi_sum = hi_base;
        if ((hi_base > {1'b0, csx_pkg::BCD_DIGIT_MAX}) || carry)
            hi_sum = hi_base + {1'b0, csx_pkg::BCD_CORRECTION};
        result = {hi_sum[3:0], lo_sum[3:0]};
        carry_out = hi_sum[4];
    end
endmodule : csx_bcd_adjust

// [rtl/csx_exec.sv]
// Purpose: execution slice for compare-skip, decimal adjust, decrement
// Assumes: instruction word and file data valid from q1 of each cycle
// Notes: file data returns combinationally for file_addr/file_bank in q2
// Summary of operation
// - skip next when file equals accumulator
// - decode greater compare from 0110 010a
// - skip when file above accumulator, flags kept
// - decode less compare from 0110 000a
// - skip when file below accumulator, flags kept
// - skipped instruction becomes one no-op cycle
// - skipped two-word instruction costs two no-ops
// - decode q1, read q2, process q3, q4 write only for decrement to file
// - a=0 access bank, a=1 bank pointer
// - extended set, a=0, f<=5fh is indexed
// - low nibble plus six if above nine or half carry set
// - high nibble corrected with half carry, carry
// - decode decrement from 0000 01da
// - decrement result to accumulator or file
// - decrement updates c, dc, n, ov, z
//
// The address-and-strobe port and the address map were left to the implementer.
module csx_exec (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // instruction stream
    input wire logic [15:0] instr,
    input wire logic next_two_word,
    input wire logic ext_set_en,
    input wire logic [3:0] bank_pointer,
    // data memory
    input wire logic [7:0] file_rdata,
    output logic [7:0] file_addr,
    output logic [3:0] file_bank,
    output logic file_indexed,
    output logic file_we,
    output logic [7:0] file_wdata,
    // core state
    output logic [7:0] accumulator,
    output logic [4:0] status_flags,
    output logic [1:0] phase_out,
    output logic skip_active,
    output logic cycle_done
);
    // ------------------------------------------------------------------
    // phase generator
    // ------------------------------------------------------------------
    csx_pkg::csx_phase_t phase;

    csx_phase u_phase (
        .clock(clock),
        .sys_rst(sys_rst),
        .phase(phase)
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic is_less;
    logic is_equal;
    logic is_greater;
    logic is_dec;
    logic is_daw;
    logic bank_mode;
    logic dest_file;

    always_comb
    begin
        is_less = (instr[15:8] & csx_pkg::OP_CMP_MASK)
            == csx_pkg::OP_CMP_LESS;
        is_equal = (instr[15:8] & csx_pkg::OP_CMP_MASK)
            == csx_pkg::OP_CMP_EQUAL;
        is_greater = (instr[15:8] & csx_pkg::OP_CMP_MASK)
            == csx_pkg::OP_CMP_GREATER;
        is_dec = (instr[15:8] & csx_pkg::OP_DEC_MASK)
            == csx_pkg::OP_DEC_FILE;
        is_daw = instr == csx_pkg::OP_DECIMAL_ADJUST;
        bank_mode = instr[csx_pkg::BIT_BANK_MODE];
        dest_file = instr[csx_pkg::BIT_DEST];
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    csx_pkg::csx_exec_t ex_r;
    csx_pkg::csx_exec_t ex_nxt;
    logic [7:0] accumulator_r;
    logic [7:0] accumulator_nxt;
    logic [4:0] flags_r;
    logic [4:0] flags_nxt;
    logic [7:0] operand_r;
    logic [7:0] operand_nxt;
    logic skip_pend_r;
    logic skip_pend_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic [3:0] bank_r;
    logic [3:0] bank_nxt;
    logic idx_r;
    logic idx_nxt;
    logic we_r;
    logic we_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;
    logic done_r;
    logic done_nxt;
    logic [8:0] diff;
    logic [4:0] nib_diff;
    logic [7:0] dec_val;

    // ------------------------------------------------------------------
    // bcd correction
    // ------------------------------------------------------------------
    logic [7:0] daw_result;
    logic daw_carry;

    csx_bcd_adjust u_bcd (
        .acc(accumulator_r),
        .half_carry(flags_r[csx_pkg::FLAG_DC]),
        .carry(flags_r[csx_pkg::FLAG_C]),
        .result(daw_result),
        .carry_out(daw_carry)
    );

    always_comb
    begin
        ex_nxt = ex_r;
        accumulator_nxt = accumulator_r;
        flags_nxt = flags_r;
        operand_nxt = operand_r;
        skip_pend_nxt = skip_pend_r;
        addr_nxt = addr_r;
        bank_nxt = bank_r;
        idx_nxt = idx_r;
        we_nxt = 1'b0;
        wdata_nxt = wdata_r;
        done_nxt = 1'b0;
        diff = {1'b0, operand_r} - {1'b0, accumulator_r};
        nib_diff = {1'b0, operand_r[3:0]} - 5'h01;
        dec_val = operand_r - 8'h01;
        case (phase)
            csx_pkg::PH_Q1:
            begin
                // decode: pick the operand bank
                addr_nxt = instr[7:0];
                idx_nxt = 1'b0;
                if (bank_mode)
                    bank_nxt = bank_pointer;
                else if (instr[7:0] >= csx_pkg::ACCESS_SPLIT)
                    bank_nxt = csx_pkg::ACCESS_BANK;
                else
                begin
                    bank_nxt = 4'h0;
                    idx_nxt = ext_set_en
                        && (instr[7:0] <= csx_pkg::INDEXED_LIMIT);
                end
            end
            csx_pkg::PH_Q2:
            begin
                if (ex_r == csx_pkg::EX_RUN)
                    operand_nxt = file_rdata;
            end
            csx_pkg::PH_Q3:
            begin
                skip_pend_nxt = 1'b0;
                if (ex_r == csx_pkg::EX_RUN)
                begin
                    // compares only raise skip; no data or flag change
                    if ((is_equal && diff == 9'h000)
                        || (is_greater && !diff[8] && diff != 9'h000)
                        || (is_less && diff[8]))
                        skip_pend_nxt = 1'b1;
                    else if (is_daw)
                    begin
                        accumulator_nxt = daw_result;
                        flags_nxt[csx_pkg::FLAG_C] = daw_carry;
                    end
                    else if (is_dec)
                    begin
                        if (dest_file)
                        begin
                            we_nxt = 1'b1;
                            wdata_nxt = dec_val;
                        end
                        else
                            accumulator_nxt = dec_val;
                        flags_nxt[csx_pkg::FLAG_C] = operand_r != 8'h00;
                        flags_nxt[csx_pkg::FLAG_DC] = !nib_diff[4];
                        flags_nxt[csx_pkg::FLAG_Z] = dec_val == 8'h00;
                        flags_nxt[csx_pkg::FLAG_N] = dec_val[7];
                        flags_nxt[csx_pkg::FLAG_OV] = operand_r == 8'h80;
                    end
                end
            end
            default:
            begin
                done_nxt = 1'b1;
                case (ex_r)
                    csx_pkg::EX_RUN:
                        if (skip_pend_r)
                            ex_nxt = csx_pkg::EX_SKIP1;
                    csx_pkg::EX_SKIP1:
                        if (next_two_word)
                            ex_nxt = csx_pkg::EX_SKIP2;
                        else
                            ex_nxt = csx_pkg::EX_RUN;
                    default:
                        ex_nxt = csx_pkg::EX_RUN;
                endcase
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ex_r <= csx_pkg::EX_RUN;
            accumulator_r <= csx_pkg::ACC_RESET;
            flags_r <= csx_pkg::FLAGS_RESET;
            operand_r <= 8'h00;
            skip_pend_r <= 1'b0;
            addr_r <= 8'h00;
            bank_r <= 4'h0;
            idx_r <= 1'b0;
            we_r <= 1'b0;
            wdata_r <= 8'h00;
            done_r <= 1'b0;
        end
        else
        begin
            ex_r <= ex_nxt;
            accumulator_r <= accumulator_nxt;
            flags_r <= flags_nxt;
            operand_r <= operand_nxt;
            skip_pend_r <= skip_pend_nxt;
            addr_r <= addr_nxt;
            bank_r <= bank_nxt;
            idx_r <= idx_nxt;
            we_r <= we_nxt;
            wdata_r <= wdata_nxt;
            done_r <= done_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic [1:0] phase_r;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            phase_r <= 2'b00;
        else
            phase_r <= phase;
    end

    assign accumulator = accumulator_r;
    assign status_flags = flags_r;
    assign file_addr = addr_r;
    assign file_bank = bank_r;
    assign file_indexed = idx_r;
    assign file_we = we_r;
    assign file_wdata = wdata_r;
    assign skip_active = ex_r != csx_pkg::EX_RUN;
    assign cycle_done = done_r;
    assign phase_out = phase_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_cmp_read;
        phase == csx_pkg::PH_Q3 && ex_r == csx_pkg::EX_RUN
            && (is_less || is_greater || is_equal);
    endsequence

    a_cmp_no_write: assert property (@(posedge clock) disable iff (sys_rst)
        s_cmp_read |=> !we_nxt && !we_r)
        else $error("compare wrote a register");
    a_cmp_acc_kept: assert property (@(posedge clock) disable iff (sys_rst)
        s_cmp_read |=> $stable(accumulator_r) && $stable(flags_r))
        else $error("compare changed accumulator or flags");
    a_greater_skip: assert property (@(posedge clock) disable iff (sys_rst)
        s_cmp_read and is_greater && operand_r > accumulator_r
        |=> skip_pend_r ##1 ex_r == csx_pkg::EX_SKIP1)
        else $error("greater compare did not skip");
    a_less_skip: assert property (@(posedge clock) disable iff (sys_rst)
        s_cmp_read and is_less
        |=> skip_pend_r == ($past(operand_r) < $past(accumulator_r)))
        else $error("less compare skip wrong");
    a_equal_skip: assert property (@(posedge clock) disable iff (sys_rst)
        s_cmp_read and is_equal
        |=> skip_pend_r == ($past(operand_r) == $past(accumulator_r)))
        else $error("equal compare skip wrong");
    a_skip_one_cyc: assert property (@(posedge clock) disable iff (sys_rst)
        ex_r == csx_pkg::EX_SKIP1 && phase == csx_pkg::PH_Q4 && !next_two_word
        |=> ex_r == csx_pkg::EX_RUN)
        else $error("single skip not one cycle");
    a_skip_two_cyc: assert property (@(posedge clock) disable iff (sys_rst)
        ex_r == csx_pkg::EX_SKIP1 && phase == csx_pkg::PH_Q4 && next_two_word
        |=> ex_r == csx_pkg::EX_SKIP2 [*4] ##1 ex_r == csx_pkg::EX_RUN)
        else $error("two-word skip not two cycles");
    a_dec_dest: assert property (@(posedge clock) disable iff (sys_rst)
        phase == csx_pkg::PH_Q3 && ex_r == csx_pkg::EX_RUN && is_dec
        && dest_file |=> we_r && wdata_r == $past(operand_r) - 8'h01)
        else $error("decrement write-back wrong");
    a_dec_zero: assert property (@(posedge clock) disable iff (sys_rst)
        phase == csx_pkg::PH_Q3 && ex_r == csx_pkg::EX_RUN && is_dec
        |=> flags_r[csx_pkg::FLAG_Z] == ($past(operand_r) == 8'h01))
        else $error("decrement zero flag wrong");
endmodule : csx_exec

// [bench/compare_skip_decadj_exec_bench.sv]
// Purpose: self-checking bench for the compare/skip/adjust/decrement slice
// Assumes: one instruction per four clocks, first q1 after reset release
// Notes: accumulator is loaded through decrement with d=0, the only way in
module compare_skip_decadj_exec_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic clock = 1'b0;
    logic sys_rst;
    logic [15:0] instr;
    logic next_two_word;
    logic ext_set_en;
    logic [3:0] bank_pointer;
    logic [7:0] file_rdata;
    logic [7:0] file_addr;
    logic [3:0] file_bank;
    logic file_indexed;
    logic file_we;
    logic [7:0] file_wdata;
    logic [7:0] accumulator;
    logic [4:0] status_flags;
    logic [1:0] phase_out;
    logic skip_active;
    logic cycle_done;
    int n_errors;
    int samples_checked;
    integer seed;
    logic [7:0] acc_m;
    logic [4:0] flags_m;
    int skip_left;
    logic two_m;

    csx_exec dut_u (
        .clock(clock),
        .sys_rst(sys_rst),
        .instr(instr),
        .next_two_word(next_two_word),
        .ext_set_en(ext_set_en),
        .bank_pointer(bank_pointer),
        .file_rdata(file_rdata),
        .file_addr(file_addr),
        .file_bank(file_bank),
        .file_indexed(file_indexed),
        .file_we(file_we),
        .file_wdata(file_wdata),
        .accumulator(accumulator),
        .status_flags(status_flags),
        .phase_out(phase_out),
        .skip_active(skip_active),
        .cycle_done(cycle_done)
    );

    always #5 clock = ~clock;

    // ------------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------------
    // flags as {n, wrap, z, half, c}; c and half mean "no borrow"
    function automatic logic [4:0] dec_flags(input logic [7:0] f);
        logic [7:0] r;
        r = f - 8'h01;
        return {r[7], f == 8'h80, r == 8'h00, f[3:0] != 4'h0, f != 8'h00};
    endfunction : dec_flags

    // high nibble sees half carry, not the low-nibble overflow
    function automatic logic [8:0] bcd_fix(input logic [7:0] w,
                                           input logic hc, input logic c);
        logic [3:0] lo;
        logic [4:0] hs;
        lo = w[3:0];
        if (lo > 4'h9 || hc)
            lo = lo + 4'h6;
        hs = {1'b0, w[7:4]} + {4'h0, hc};
        if (hs > 5'h09 || c)
            hs = hs + 5'h06;
        return {hs[4], hs[3:0], lo};
    endfunction : bcd_fix

    function automatic logic cmp_hit(input logic [7:0] hi,
                                     input logic [7:0] f, input logic [7:0] w);
        logic [7:0] op;
        op = hi & csx_pkg::OP_CMP_MASK;
        if (op == csx_pkg::OP_CMP_GREATER)
            return f > w;
        if (op == csx_pkg::OP_CMP_LESS)
            return f < w;
        return f == w;
    endfunction : cmp_hit

    // ------------------------------------------------------------------
    // compare and closing tasks
    // ------------------------------------------------------------------
    task automatic chk_val(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    task automatic chk_bit(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // one instruction cycle; results looked at in q4
    // ------------------------------------------------------------------
    task automatic run(input logic [15:0] ins, input logic [7:0] fd,
                       input logic nt);
        logic [7:0] hi;
        logic [7:0] f;
        logic is_dec;
        logic is_cmp;
        logic idx;
        logic we_e;
        logic [8:0] dj;
        hi = ins[15:8];
        f = ins[7:0];
        is_dec = (hi & csx_pkg::OP_DEC_MASK) == csx_pkg::OP_DEC_FILE;
        is_cmp = (hi & 8'hfe) inside {csx_pkg::OP_CMP_LESS,
            csx_pkg::OP_CMP_EQUAL, csx_pkg::OP_CMP_GREATER};
        we_e = 1'b0;
        if (skip_left == 0)
            two_m = nt;
        instr <= ins;
        file_rdata <= fd;
        next_two_word <= two_m;
        repeat (3) @(posedge clock);
        #1;
        chk_val("phase_out", 8'h03, {6'h00, phase_out});
        chk_bit("cycle_done", 1'b0, cycle_done);
        if (skip_left != 0)
        begin
            skip_left--;
            chk_bit("skip_active", 1'b1, skip_active);
        end
        else
        begin
            chk_bit("skip_active", 1'b0, skip_active);
            idx = ext_set_en & ~hi[0] & (f <= csx_pkg::INDEXED_LIMIT);
            if (is_dec || is_cmp)
            begin
                chk_val("file_addr", f, file_addr);
                chk_bit("file_indexed", idx, file_indexed);
                chk_val("file_bank", {4'h0, hi[0] ? bank_pointer :
                    (f >= 8'h80 ? 4'hf : 4'h0)}, {4'h0, file_bank});
            end
            if (is_dec)
            begin
                flags_m = dec_flags(fd);
                we_e = ins[csx_pkg::BIT_DEST];
                if (!we_e)
                    acc_m = fd - 8'h01;
            end
            else if (ins == csx_pkg::OP_DECIMAL_ADJUST)
            begin
                dj = bcd_fix(acc_m, flags_m[1], flags_m[0]);
                acc_m = dj[7:0];
                flags_m[0] = dj[8];
            end
            else if (is_cmp && cmp_hit(hi, fd, acc_m))
                skip_left = two_m ? 2 : 1;
            if (we_e)
                chk_val("file_wdata", fd - 8'h01, file_wdata);
        end
        chk_bit("file_we", we_e, file_we);
        chk_val("accumulator", acc_m, accumulator);
        chk_val("status_flags", {3'h0, flags_m},
            {3'h0, status_flags});
        @(posedge clock);
    endtask : run

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [7:0] ops [6];
        logic [31:0] r;
        logic [7:0] hi;
        int unsigned k;
        ops = '{8'h04, 8'h00, 8'h62, 8'h64, 8'h60, 8'h6a};
        seed = 32'ha65a07fc;
        n_errors = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        instr = 16'h0000;
        next_two_word = 1'b0;
        ext_set_en = 1'b0;
        bank_pointer = 4'h3;
        file_rdata = 8'h00;
        acc_m = csx_pkg::ACC_RESET;
        flags_m = csx_pkg::FLAGS_RESET;
        skip_left = 0;
        two_m = 1'b0;
        @(posedge clock);
        #1;
        chk_val("accumulator", 8'h00, accumulator);
        chk_val("status_flags", 8'h00, {3'h0, status_flags});
        @(posedge clock);
        sys_rst <= 1'b0;
        // wrap to ff, then adjust with both carries clear
        run({8'h04, 8'h20}, 8'h00, 1'b0);
        run(csx_pkg::OP_DECIMAL_ADJUST, 8'h00, 1'b0);
        run({8'h06, 8'h80}, 8'h80, 1'b0);
        run({8'h04, 8'h81}, 8'h10, 1'b0);
        run(csx_pkg::OP_DECIMAL_ADJUST, 8'h00, 1'b0);
        ext_set_en <= 1'b1;
        run({8'h04, 8'h5f}, 8'h01, 1'b0);
        run({8'h05, 8'h22}, 8'h41, 1'b0);
        run({8'h62, 8'h60}, acc_m, 1'b1);
        run({8'h05, 8'h11}, 8'h33, 1'b1);
        run({8'h05, 8'h11}, 8'h33, 1'b1);
        run({8'h65, 8'h40}, acc_m + 8'h01, 1'b0);
        run({8'h07, 8'h40}, 8'h33, 1'b0);
        run({8'h64, 8'h40}, acc_m, 1'b0);
        run({8'h61, 8'h90}, acc_m, 1'b0);
        run({8'h60, 8'h90}, acc_m - 8'h01, 1'b0);
        run({8'h06, 8'h90}, 8'h55, 1'b0);
        repeat (160)
        begin
            r = $random(seed);
            k = $unsigned($random(seed)) % 6;
            hi = ops[k] | (k == 0 ? {6'h00, r[12:11]} : {7'h00, r[11]});
            bank_pointer <= r[16:13];
            ext_set_en <= r[17];
            run(k == 1 ? csx_pkg::OP_DECIMAL_ADJUST : {hi, r[31:24]},
                r[8] ? acc_m + {6'h00, r[10:9]} - 8'h01 : r[7:0],
                r[18]);
        end
        test_done;
    end

    // hang guard, well beyond the roughly 700 clocks the run needs
    initial
    begin
        #200000;
        n_errors++;
        test_done;
    end
endmodule : compare_skip_decadj_exec_bench
